//--- logic/dcs_status_words.sv
/*
  Status-word logic of the drum controller: instruction status word,
  first parity error capture word and error tally word, plus the
  two-word read/write sequence check.
  Assumes command words arrive already taken by the command-word
  handshake as one-cycle strobes on clk, and that drum fault lines are
  asynchronous pins (synchronised here). Events from the transfer
  engine (parity, overrun, preamble miss, done) are same-clock pulses.
*/
`default_nettype none
module dcs_status_words
  import dcs_pkg::*;
#(
  parameter int TRK_BITS = dcs_pkg::TRK_W,   // Track address width
  parameter int WRD_BITS = dcs_pkg::WRD_W    // Word address width
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Command words already accepted by the handshake
  input  wire logic                       cmdValid,
  input  wire logic [dcs_pkg::OPC_W-1:0]  cmdOpcode,
  input  wire logic [18:0]                cmdAddr,
  input  wire logic [dcs_pkg::PROT_W-1:0] protWord,
  input  wire logic [dcs_pkg::PROT_W-1:0] protSwitches,
  // Transfer engine events (same clock)
  input  wire logic                       xferDone,
  input  wire logic                       syncMiss,
  input  wire logic                       drumParErr,
  input  wire logic                       drumParByte2,
  input  wire logic                       bufParErr,
  input  wire logic                       bufParFromB,
  input  wire logic                       regByteErr,
  input  wire logic                       xferStarve,
  input  wire logic [dcs_pkg::TRK_W-1:0]  curTrack,
  input  wire logic [dcs_pkg::WRD_W-1:0]  curWord,
  // Drum unit fault pins (asynchronous)
  input  wire logic                       clockMissing,
  input  wire logic                       powerFault,
  input  wire logic                       trackSelBad,
  input  wire logic                       clockTolErr,
  input  wire logic                       pressureLow,
  input  wire logic                       overTemp,
  input  wire logic                       speedErr,
  // Word returned to the computer, and transfer state
  output logic                            statusValid,
  output logic [dcs_pkg::WORD_W-1:0]      statusWord,
  output logic                            xferRun,
  output logic                            xferIsWrite,
  output logic                            xferHold
);
  import dcs_pkg::*;

  // ==========================================================
  // Drum fault synchronisers (two flip-flops each)
  logic [6:0] faultMeta_ff;   // First stage, read only by second
  logic [6:0] fault_ff;       // Synchronised faults, [6]=clock loss
  logic [PROT_W-1:0] swMeta_ff;  // Protect switch first stage
  logic [PROT_W-1:0] sw_ff;      // Synchronised protect switches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      faultMeta_ff <= 7'h00;
      fault_ff     <= 7'h00;
      swMeta_ff    <= 12'h000;
      sw_ff        <= 12'h000;
    end else begin
      faultMeta_ff <= {clockMissing, powerFault, trackSelBad, clockTolErr,
                       pressureLow, overTemp, speedErr};
      fault_ff     <= faultMeta_ff;
      swMeta_ff    <= protSwitches;
      sw_ff        <= swMeta_ff;
    end
  end

  // ==========================================================
  // Instruction decode
  logic        busy_ff;        // Read/write in progress
  logic        isWrite_ff;     // Current transfer is a write
  logic        firstSeen_ff;   // First word taken, waiting for second
  logic        firstWrite_ff;  // Pending first word was a write
  logic [18:0] beginAddr_ff;   // Begin address of pending pair
  logic [PROT_W-1:0] prot_ff;  // Memory protect flip-flops
  logic        stale_ff;       // Status from last instruction held

  wire isWr1  = cmdValid && (cmdOpcode == OP_WR1);
  wire isRd1  = cmdValid && (cmdOpcode == OP_RD1);
  wire isWr2  = cmdValid && (cmdOpcode == OP_WR2);
  wire isRd2  = cmdValid && (cmdOpcode == OP_RD2);
  wire isMclr = cmdValid && (cmdOpcode == OP_MCLR);
  wire isTerm = cmdValid && (cmdOpcode == OP_TERM);
  wire isPst  = cmdValid && (cmdOpcode == OP_PSTAT);
  wire isEct  = cmdValid && (cmdOpcode == OP_ECNT);
  wire isIst  = cmdValid && (cmdOpcode == OP_ISTAT);
  wire isProt = cmdValid && (cmdOpcode == OP_PROT);
  wire isTest = cmdValid && (cmdOpcode >= OP_TEST);
  // Anything not listed is illegal
  wire isIllegal = cmdValid && !(isWr1 || isRd1 || isWr2 || isRd2 || isMclr || isTerm
                   || isPst || isEct || isIst || isProt || isTest);
  // Correct second word matches the pending first word
  wire goodSecond = firstSeen_ff && ((firstWrite_ff && isWr2) || (!firstWrite_ff && isRd2));
  // Second word before first, or wrong second word
  wire seqErr = ((isWr2 || isRd2) && !goodSecond)
              || (firstSeen_ff && cmdValid && !goodSecond && !isMclr && !isTerm);
  // Address checks on the end word
  wire [TRK_W-1:0] endTrk = cmdAddr[18:10];
  wire [TRK_W-1:0] begTrk = beginAddr_ff[18:10];
  wire addrErr = goodSecond && ((beginAddr_ff >= cmdAddr)
                 || (endTrk >= TRK_COUNT) || (begTrk >= TRK_COUNT));
  // Tracks grouped into protect sections of 32 tracks each
  wire [3:0] secBeg = begTrk[8:5];
  wire [3:0] secEnd = endTrk[8:5];
  logic lockHit;
  always_comb begin
    lockHit = 1'b0;
    for (int s = 0; s < PROT_W; s++) begin
      if (prot_ff[s] && (4'(s) >= secBeg) && (4'(s) <= secEnd)) begin
        lockHit = 1'b1;
      end
    end
  end
  wire lockErr = goodSecond && firstWrite_ff && lockHit;
  wire startXfer = goodSecond && !addrErr && !lockErr;

  // ==========================================================
  // Instruction status flags (master clear wins over set)
  logic [3:0] instErr_ff;  // Sequence, address, lockout, illegal
  logic       parity_ff;   // Parity during transfer
  logic       sync_ff;     // Preamble missing
  logic       normal_ff;   // Normal completion
  wire [3:0] instErrSet = {isIllegal, lockErr, addrErr, seqErr};
  wire       drumFail   = |fault_ff;
  wire       invalidFn  = |instErr_ff;
  wire       anyPar     = busy_ff && (drumParErr || bufParErr);
  wire       doneOk     = busy_ff && xferDone && !parity_ff && !anyPar && !sync_ff
                          && !syncMiss && !drumFail && !invalidFn;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instErr_ff <= 4'h0;
      parity_ff  <= 1'b0;
      sync_ff    <= 1'b0;
      normal_ff  <= 1'b0;
      stale_ff   <= 1'b0;
    end else begin
      // Master clear or a first read/write word starts fresh status
      if (isMclr || isWr1 || isRd1) begin
        instErr_ff <= instErrSet;
        parity_ff  <= 1'b0;
        sync_ff    <= 1'b0;
        normal_ff  <= 1'b0;
      end else begin
        instErr_ff <= instErr_ff | instErrSet;
        parity_ff  <= parity_ff | anyPar;
        sync_ff    <= sync_ff | (busy_ff && syncMiss);
        normal_ff  <= normal_ff | doneOk;
      end
      // Standby once any instruction other than master clear leaves status behind
      stale_ff <= isMclr ? 1'b0 : (stale_ff | (cmdValid && !isMclr));
    end
  end

  // ==========================================================
  // Sequencing, transfer state and protect flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff       <= 1'b0;
      isWrite_ff    <= 1'b0;
      firstSeen_ff  <= 1'b0;
      firstWrite_ff <= 1'b0;
      beginAddr_ff  <= 19'h00000;
      prot_ff       <= 12'h000;
    end else begin
      // Begin address word first, end address second
      if (isWr1 || isRd1) begin
        firstSeen_ff  <= !busy_ff;
        firstWrite_ff <= isWr1;
        beginAddr_ff  <= cmdAddr;
      end else if (cmdValid) begin
        firstSeen_ff <= 1'b0;
      end
      // Transfer runs until done or stopped
      if (isMclr || isTerm || (busy_ff && (xferDone || syncMiss))) begin
        busy_ff <= 1'b0;
      end else if (startXfer) begin
        busy_ff    <= 1'b1;
        isWrite_ff <= firstWrite_ff;
      end
      // Protect word from computer, switches always OR in
      prot_ff <= (isProt ? protWord : prot_ff) | sw_ff;
    end
  end

  // ==========================================================
  // First parity error capture
  logic             pAvail_ff;
  logic [1:0]       pByte_ff;
  logic [1:0]       pBuf_ff;
  logic             pRw_ff;
  logic [TRK_W-1:0] pTrk_ff;
  logic [WRD_W-1:0] pWrd_ff;
  wire capture = anyPar && !pAvail_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pAvail_ff <= 1'b0;
      pByte_ff  <= 2'h0;
      pBuf_ff   <= 2'h0;
      pRw_ff    <= 1'b0;
      pTrk_ff   <= 9'h000;
      pWrd_ff   <= 10'h000;
    end else if (capture) begin
      pAvail_ff <= 1'b1;
      // Drum error wins the designator if both arrive together
      pByte_ff  <= drumParErr ? {drumParByte2, !drumParByte2} : 2'h0;
      pBuf_ff   <= drumParErr ? 2'h0 : {bufParFromB, !bufParFromB};
      pRw_ff    <= isWrite_ff;
      pTrk_ff   <= curTrack;
      pWrd_ff   <= curWord;
    end else if (isMclr) begin
      pAvail_ff <= 1'b0;
      pByte_ff  <= 2'h0;
      pBuf_ff   <= 2'h0;
      pRw_ff    <= 1'b0;
      pTrk_ff   <= 9'h000;
      pWrd_ff   <= 10'h000;
    end
  end

  // ==========================================================
  // Saturating error counters; an event beats master clear
  logic [OVR_W-1:0] ovrCnt_ff;
  logic [CNT_W-1:0] bufCnt_ff;
  logic [CNT_W-1:0] regCnt_ff;
  wire ovrInc = busy_ff && xferStarve;
  wire bufInc = busy_ff && bufParErr;
  wire regInc = busy_ff && regByteErr;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovrCnt_ff <= 9'h000;
      bufCnt_ff <= 10'h000;
      regCnt_ff <= 10'h000;
    end else begin
      if (ovrInc) begin
        ovrCnt_ff <= (&ovrCnt_ff) ? ovrCnt_ff : ovrCnt_ff + 9'h001;
      end else if (isMclr) begin
        ovrCnt_ff <= 9'h000;
      end
      if (bufInc) begin
        bufCnt_ff <= (&bufCnt_ff) ? bufCnt_ff : bufCnt_ff + 10'h001;
      end else if (isMclr) begin
        bufCnt_ff <= 10'h000;
      end
      if (regInc) begin
        regCnt_ff <= (&regCnt_ff) ? regCnt_ff : regCnt_ff + 10'h001;
      end else if (isMclr) begin
        regCnt_ff <= 10'h000;
      end
    end
  end

  // ==========================================================
  // Word assembly
  wire idle = !busy_ff && !firstSeen_ff;
  wire [WORD_W-1:0] iswWord = {normal_ff, parity_ff, sync_ff, drumFail,
                               idle && !stale_ff, idle && stale_ff,
                               invalidFn, prot_ff,
                               fault_ff,
                               instErr_ff};
  wire [WORD_W-1:0] pewWord = {pAvail_ff, pByte_ff, pBuf_ff, pRw_ff, 5'h00,
                               pTrk_ff, pWrd_ff};
  wire [WORD_W-1:0] etwWord = {(|ovrCnt_ff) || (|bufCnt_ff) || (|regCnt_ff),
                               ovrCnt_ff, bufCnt_ff, regCnt_ff};
  // Instruction words and transfer ends that return the status word
  wire endOfInstr = (busy_ff && (xferDone || syncMiss)) || isMclr || isTerm || isProt || isIst
                    || isIllegal || seqErr || addrErr || lockErr;
  wire sendNow   = endOfInstr || (anyPar && busy_ff);
  wire [1:0] sel = isPst ? SEL_PEW : (isEct ? SEL_ETW : SEL_ISW);

  // ==========================================================
  // Output registers; a word leaves two cycles after its trigger so
  // that it carries the status the trigger has just left behind
  logic       sendPend_ff;  // A word is due next cycle
  logic [1:0] selPend_ff;   // Which word is due
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sendPend_ff <= 1'b0;
      selPend_ff  <= SEL_ISW;
      statusValid <= 1'b0;
      statusWord  <= ZERO_WORD;
      xferRun     <= 1'b0;
      xferIsWrite <= 1'b0;
      xferHold    <= 1'b0;
    end else begin
      sendPend_ff <= sendNow || isPst || isEct;
      selPend_ff  <= sel;
      statusValid <= sendPend_ff;
      statusWord  <= (selPend_ff == SEL_PEW) ? pewWord
                     : ((selPend_ff == SEL_ETW) ? etwWord : iswWord);
      xferRun     <= busy_ff;
      xferIsWrite <= isWrite_ff;
      xferHold    <= busy_ff && xferStarve;
    end
  end

  // ==========================================================
  // Checks
  property p_seq;
    @(posedge clk) disable iff (!resetn)
      (isWr2 && !firstSeen_ff) |=> instErr_ff[0];
  endproperty
  a_seq: assert property (p_seq) else $error("Early second word not flagged");
  property p_sat;
    @(posedge clk) disable iff (!resetn)
      (&ovrCnt_ff) && !isMclr |=> (&ovrCnt_ff);
  endproperty
  a_sat: assert property (p_sat) else $error("Overrun count wrapped");
  property p_first;
    @(posedge clk) disable iff (!resetn)
      (pAvail_ff && !isMclr) |=> $stable(pTrk_ff) && $stable(pWrd_ff);
  endproperty
  a_first: assert property (p_first) else $error("Capture overwritten");
  property p_drum;
    @(posedge clk) disable iff (!resetn)
      statusValid |-> (statusWord[ISW_DRUMFAIL] == (|statusWord[10:4]))
                      || $past(isPst || isEct, 2);
  endproperty
  a_drum: assert property (p_drum) else $error("Drum failure mismatch");
  property p_inv;
    @(posedge clk) disable iff (!resetn)
      (isIllegal && !isMclr) |=> ##1 (statusWord[ISW_ILLEGAL] && statusWord[ISW_INVALID]);
  endproperty
  a_inv: assert property (p_inv) else $error("Illegal code not reported");
  property p_norm;
    @(posedge clk) disable iff (!resetn)
      normal_ff |-> !parity_ff && !sync_ff;
  endproperty
  a_norm: assert property (p_norm) else $error("Normal completion with errors");
  property p_par;
    @(posedge clk) disable iff (!resetn)
      (anyPar && !isMclr && !isWr1 && !isRd1) |=> parity_ff ##1 statusValid;
  endproperty
  a_par: assert property (p_par) else $error("Parity not reported at once");
  property p_mclr;
    @(posedge clk) disable iff (!resetn)
      (isMclr && !anyPar && !xferStarve) |=> !pAvail_ff && (ovrCnt_ff == 9'h000) ##1
        (statusWord[ISW_CLEARED]);
  endproperty
  a_mclr: assert property (p_mclr) else $error("Master clear incomplete");
endmodule : dcs_status_words
`default_nettype wire

//--- logic/dcs_pkg.sv
/*
  Package for the drum controller status-word block: bit positions,
  instruction codes, reset values and field widths.
  Assumes a single 40 MHz clock domain and an active-low async reset.
*/
`default_nettype none
package dcs_pkg;
  // ==========================================================
  // Instruction status word bit positions
  localparam int ISW_NORMAL   = 29;
  localparam int ISW_PARITY   = 28;
  localparam int ISW_SYNC     = 27;
  localparam int ISW_DRUMFAIL = 26;
  localparam int ISW_CLEARED  = 25;
  localparam int ISW_STANDBY  = 24;
  localparam int ISW_INVALID  = 23;
  localparam int ISW_PROT_HI  = 22;
  localparam int ISW_PROT_LO  = 11;
  localparam int ISW_CLKLOSS  = 10;
  localparam int ISW_POWER    = 9;
  localparam int ISW_TRKSEL   = 8;
  localparam int ISW_CLKERR   = 7;
  localparam int ISW_PRESS    = 6;
  localparam int ISW_TEMP     = 5;
  localparam int ISW_SPEED    = 4;
  localparam int ISW_ILLEGAL  = 3;
  localparam int ISW_LOCKOUT  = 2;
  localparam int ISW_ADDRERR  = 1;
  localparam int ISW_SEQERR   = 0;
  // ==========================================================
  // First parity error word fields
  localparam int PEW_AVAIL    = 29;
  localparam int PEW_BYTE_LO  = 27;
  localparam int PEW_BUF_LO   = 25;
  localparam int PEW_RW       = 24;
  localparam int PEW_TRK_LO   = 10;
  localparam int PEW_WRD_LO   = 0;
  // ==========================================================
  // Error tally word fields
  localparam int ETW_AVAIL    = 29;
  localparam int ETW_OVR_LO   = 20;
  localparam int ETW_BUF_LO   = 10;
  localparam int ETW_REG_LO   = 0;
  // ==========================================================
  // Field widths and limits
  localparam int WORD_W       = 30;
  localparam int TRK_W        = 9;
  localparam int WRD_W        = 10;
  localparam int PROT_W       = 12;
  localparam int OVR_W        = 9;
  localparam int CNT_W        = 10;
  localparam logic [TRK_W-1:0] TRK_COUNT = 9'h180;  // 384 tracks exist
  // ==========================================================
  // Instruction codes (top bits of a command word)
  localparam int OPC_W = 4;
  typedef enum logic [OPC_W-1:0] {
    OP_WR1    = 4'h1,
    OP_WR2    = 4'h2,
    OP_RD1    = 4'h3,
    OP_RD2    = 4'h4,
    OP_PSTAT  = 4'h5,
    OP_ECNT   = 4'h6,
    OP_MCLR   = 4'h7,
    OP_TERM   = 4'h8,
    OP_PROT   = 4'h9,
    OP_ISTAT  = 4'hA,
    OP_TEST   = 4'hB
  } dcs_op_t;
  // Which word is returned
  localparam logic [1:0] SEL_ISW = 2'h0;
  localparam logic [1:0] SEL_PEW = 2'h1;
  localparam logic [1:0] SEL_ETW = 2'h2;
  // Reset values
  localparam logic [WORD_W-1:0] ZERO_WORD = 30'h0;
endpackage : dcs_pkg
`default_nettype wire

//--- verification/dcs_drum_model.sv
/*
  Drum unit model for the status-word bench: drives the seven fault
  levels that the controller reports in its instruction status word.
  Assumes the bench chooses which faults are present through faultSel.
*/
`default_nettype none
module dcs_drum_model (
  // Clock
  input  wire logic       clk,
  // Faults requested by the bench, bit 6 clock loss .. bit 0 speed
  input  wire logic [6:0] faultSel,
  // Fault pins toward the controller
  output wire logic       clockMissing,
  output wire logic       powerFault,
  output wire logic       trackSelBad,
  output wire logic       clockTolErr,
  output wire logic       pressureLow,
  output wire logic       overTemp,
  output wire logic       speedErr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Fault levels
  logic [6:0] pinsFf = 7'h00;  // Levels, moved off the sampling edge
  // Faults change on the falling edge, like a free-running drum
  always @(negedge clk) begin
    pinsFf <= faultSel;
  end
  assign {clockMissing, powerFault, trackSelBad, clockTolErr,
          pressureLow, overTemp, speedErr} = pinsFf;
endmodule // dcs_drum_model
`default_nettype wire

//--- verification/drum_controller_status_words_tb_top.sv
/*
  Self-checking bench for the status-word block: table of read/write
  cases, then hand tests for sequence, faults, protect and counters.
  Assumes the drum model file is compiled first.
*/
`default_nettype none
module drum_controller_status_words_tb_top;
  import dcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk = 1'b0, resetn = 1'b0, cmdValid = 1'b0;
  logic [3:0] cmdOpcode = 4'h0;
  logic [18:0] cmdAddr = 19'h0;
  logic [11:0] protWord = 12'h000, protSwitches = 12'h000;
  logic xferDone = 1'b0, syncMiss = 1'b0, drumParErr = 1'b0, bufParErr = 1'b0;
  logic regByteErr = 1'b0, xferStarve = 1'b0;
  logic byte2 = 1'b0, fromB = 1'b0;  // Error designators: byte 1, buffer A
  logic [6:0] faultSel = 7'h00;
  wire logic clkMis, pwr, trk, clkTol, press, temp, spd;
  logic statusValid, xferRun, xferIsWrite, xferHold;
  logic [29:0] statusWord, got;
  logic gotV;
  int miscompares = 0, nTests = 0, cyc = 0;
  typedef struct packed {
    logic wr; logic [18:0] b; logic [18:0] e; logic [4:0] evt; logic [29:0] val;
  } dcs_row_t;
  dcs_row_t rows [6];
  // ==========================================================
  // Design and drum model
  dcs_status_words dut (.clk(clk), .resetn(resetn), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .protWord(protWord),
    .protSwitches(protSwitches), .xferDone(xferDone), .syncMiss(syncMiss),
    .drumParErr(drumParErr), .drumParByte2(byte2), .bufParErr(bufParErr),
    .bufParFromB(fromB), .regByteErr(regByteErr), .xferStarve(xferStarve),
    .curTrack(9'h005), .curWord(10'h007), .clockMissing(clkMis),
    .powerFault(pwr), .trackSelBad(trk), .clockTolErr(clkTol),
    .pressureLow(press), .overTemp(temp), .speedErr(spd),
    .statusValid(statusValid), .statusWord(statusWord), .xferRun(xferRun),
    .xferIsWrite(xferIsWrite), .xferHold(xferHold));
  dcs_drum_model drum (.clk(clk), .faultSel(faultSel), .clockMissing(clkMis),
    .powerFault(pwr), .trackSelBad(trk), .clockTolErr(clkTol),
    .pressureLow(press), .overTemp(temp), .speedErr(spd));
  // ==========================================================
  // Clock and hang guard
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================
  // Tasks
  // Compare and count
  task automatic check(input string name, input logic [29:0] seen,
                       input logic [29:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One cycle; capture any returned word
  task automatic tick();
    @(negedge clk);
    if (statusValid === 1'b1) begin
      got = statusWord;
      gotV = 1'b1;
    end
  endtask
  // One command word through the handshake
  task automatic cmd(input logic [3:0] op, input logic [18:0] a);
    cmdOpcode = op;
    cmdAddr = a;
    cmdValid = 1'b1;
    tick();
    cmdValid = 1'b0;
  endtask
  // Command expected to return a word
  task automatic req(input logic [3:0] op, input logic [18:0] a);
    gotV = 1'b0;
    cmd(op, a);
    repeat (4) tick();
    check("returned", {29'h0, gotV}, 30'h1);
  endtask
  // Two-word transfer with event pulses; keeps the last word returned
  task automatic xfer(input logic wr, input logic [18:0] b, input logic [18:0] e,
                      input logic [4:0] evt, input int reps);
    cmd(wr ? OP_WR1 : OP_RD1, b);
    gotV = 1'b0;
    cmd(wr ? OP_WR2 : OP_RD2, e);
    for (int i = 0; i < 8 && xferRun !== 1'b1; i++) tick();
    if (xferRun === 1'b1) check("mode", {29'h0, xferIsWrite}, {29'h0, wr});
    for (int i = 0; i < reps; i++) begin
      drumParErr = evt[0];
      bufParErr = evt[1] && (i > 0 || !evt[0]);
      syncMiss = evt[2];
      xferStarve = evt[3];
      regByteErr = evt[4];
      tick();
      if (i == 0) check("hold", {29'h0, xferHold}, {29'h0, evt[3]});
      {drumParErr, bufParErr, syncMiss, xferStarve, regByteErr} = 5'h00;
      tick();
    end
    xferDone = 1'b1;
    tick();
    xferDone = 1'b0;
    repeat (6) tick();
    check("returned", {29'h0, gotV}, 30'h1);
  endtask
  // Verdict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{1'b1, 19'h00000, 19'h00010, 5'h00, 30'h2000_0000},
             '{1'b0, 19'h00400, 19'h00800, 5'h01, 30'h1000_0000},
             '{1'b0, 19'h00400, 19'h00800, 5'h04, 30'h0800_0000},
             '{1'b1, 19'h00010, 19'h00010, 5'h00, 30'h0080_0002},
             '{1'b1, 19'h00000, 19'h60000, 5'h00, 30'h0080_0002},
             '{1'b0, 19'h00020, 19'h00010, 5'h00, 30'h0080_0002}};
    repeat (5) @(negedge clk);
    check("reset word", statusWord, 30'h0);
    check("reset valid", {29'h0, statusValid}, 30'h0);
    resetn = 1'b1;
    // Table of read/write cases
    foreach (rows[i]) begin
      req(OP_MCLR, 19'h0);
      xfer(rows[i].wr, rows[i].b, rows[i].e, rows[i].evt, 1);
      check("isw row", got & 30'h3880_000F, rows[i].val);
    end
    req(OP_ISTAT, 19'h0);
    check("standby", got & 30'h0300_0000, 30'h0100_0000);
    req(OP_MCLR, 19'h0);
    check("cleared", got & 30'h03FF_F80F, 30'h0200_0000);
    // Sequence and instruction-content errors
    req(OP_WR2, 19'h00010);
    check("early second", got & 30'h0080_0001, 30'h0080_0001);
    cmd(OP_WR1, 19'h0);
    req(OP_RD1, 19'h00010);
    check("wrong second", got & 30'h0080_0001, 30'h0080_0001);
    cmd(OP_RD1, 19'h0);
    req(OP_MCLR, 19'h0);
    check("clear second", got & 30'h0280_0001, 30'h0200_0000);
    req(4'h0, 19'h0);
    check("illegal", got & 30'h0080_0008, 30'h0080_0008);
    req(OP_TERM, 19'h0);
    gotV = 1'b0;
    cmd(OP_TEST, 19'h0);
    repeat (4) tick();
    check("test silent", {29'h0, gotV}, 30'h0);
    // Drum fault pins, one at a time
    for (int i = 0; i < 7; i++) begin
      faultSel = 7'(1 << i);
      repeat (4) tick();
      req(OP_ISTAT, 19'h0);
      check("fault", got & 30'h0400_07F0, 30'h0400_0000 | 30'(1 << (i + 4)));
    end
    faultSel = 7'h00;
    // Protect flops and write lockout
    protWord = 12'h801;
    protSwitches = 12'h010;
    req(OP_PROT, 19'h0);
    req(OP_ISTAT, 19'h0);
    check("protect", {18'h00000, got[22:11]}, 30'h0000_0811);
    xfer(1'b1, 19'h00000, 19'h00005, 5'h00, 1);
    check("lockout", got & 30'h2080_0004, 30'h0080_0004);
    protWord = 12'h000;
    protSwitches = 12'h000;
    repeat (3) tick();
    req(OP_PROT, 19'h0);
    // First error capture: drum byte 1, then a buffer error ignored
    req(OP_MCLR, 19'h0);
    xfer(1'b0, 19'h00400, 19'h00800, 5'h03, 2);
    req(OP_PSTAT, 19'h0);
    check("capture", got, 30'h2800_1407);
    req(OP_MCLR, 19'h0);
    xfer(1'b1, 19'h00400, 19'h00800, 5'h02, 1);
    req(OP_PSTAT, 19'h0);
    check("buf capture", got & 30'h3FF8_0000, 30'h2300_0000);
    // Counters, single and saturated
    req(OP_MCLR, 19'h0);
    xfer(1'b0, 19'h00400, 19'h00800, 5'h1A, 1);
    req(OP_ECNT, 19'h0);
    check("tally", got, 30'h2010_0401);
    req(OP_MCLR, 19'h0);
    xfer(1'b0, 19'h00400, 19'h00800, 5'h18, 1030);
    req(OP_ECNT, 19'h0);
    check("tally sat", got, 30'h3FF0_03FF);
    req(OP_MCLR, 19'h0);
    req(OP_ECNT, 19'h0);
    check("tally clr", got, 30'h0);
    req(OP_PSTAT, 19'h0);
    check("capture clr", got, 30'h0);
    test_done();
  end
endmodule // drum_controller_status_words_tb_top
`default_nettype wire
